//--- verilog/efc_consts.svh
`ifndef EFC_CONSTS_SVH
`define EFC_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define EFC_ADDR_CTRL 8'h00
`define EFC_ADDR_LINE 8'h01
`define EFC_ADDR_OFFSET 8'h02
`define EFC_ADDR_TS16 8'h03
`define EFC_ADDR_MASK0 8'h04
`define EFC_ADDR_MASK1 8'h05
`define EFC_ADDR_MASK2 8'h06
`define EFC_ADDR_MASK3 8'h07
`define EFC_ADDR_PEND0 8'h08
`define EFC_ADDR_PEND1 8'h09
`define EFC_ADDR_PEND2 8'h0a
`define EFC_ADDR_PEND3 8'h0b
`define EFC_ADDR_STATUS 8'h10
`define EFC_ADDR_VECTOR 8'h12
`define EFC_ADDR_DLINK 8'h14
`define EFC_ADDR_VIO_HI 8'h1c
`define EFC_ADDR_VIO_LO 8'h1d

// ****************************************
// Control and line register fields
// ****************************************
`define EFC_CTRL_ALARM 0
`define EFC_CTRL_SIDE 1
`define EFC_CTRL_SUSPEND 2
`define EFC_CTRL_LOOP 3
`define EFC_CTRL_TS16 4
`define EFC_CTRL_CRC_MODIFY_ENABLE 5
`define EFC_CTRL_MODE 6
`define EFC_CTRL_ALIGN 7
`define EFC_LINE_SWRST 7

// ****************************************
// Reset values
// ****************************************
`define EFC_CTRL_RESET 8'h04
`define EFC_LINE_CODE_RESET 2'h0
`define EFC_MASK_RESET 30'h000000ff

// ****************************************
// Interrupt sources and framing
// ****************************************
`define EFC_IRQ_COUNT 30
`define EFC_IRQ_VIO_OVF 6
`define EFC_FRAME_BITS 256
`define EFC_TS16_FIRST 8'h80
`define EFC_FAS_WORD 7'h1b
`define EFC_AFTER_FAS 8'h08

`endif

//--- verilog/efc_pkg.sv
package efc_pkg;

    // ****************************************
    // Operating mode
    // ****************************************
    typedef enum logic [3:0] {
        EFC_NORMAL = 4'b0001,
        EFC_TRANSPARENT = 4'b0010,
        EFC_PASS = 4'b0100,
        EFC_OTHER = 4'b1000
    } efc_mode_type;

    // ****************************************
    // Block state
    // ****************************************
    typedef struct packed {
        logic [2:0] alarmSync;
        logic [2:0] clkSync;
        logic [2:0] pulseSync;
        logic [2:0] dinSync;
        logic [2:0] rxSync;
        logic alarmPin;
        logic clkLevel;
        logic pulseLevel;
        logic dinLevel;
        logic rxLevel;
        logic [7:0] bitCnt;
        logic frameOdd;
        logic dinBit;
        logic [7:0] rxPos;
        logic [6:0] rxHist;
        logic [255:0] frameBuf;
        logic [7:0] ctrl;
        logic [1:0] lineCode;
        logic [7:0] offset;
        logic [7:0] ts16Val;
        logic dlBit;
        logic [29:0] mask;
        logic [29:0] pend;
        logic [7:0] vector;
        logic [15:0] vioCnt;
        logic crcErrSeen;
        logic crcFix;
        logic txLine;
        logic serialOut;
        logic irqN;
        logic [7:0] rdData;
    } efc_state_type;

endpackage : efc_pkg

//--- verilog/efc_framer_ctrl.sv
// The implementer's own choice: the strobed register port.
`include "efc_consts.svh"

// Notes on behaviour
// - Alarm pin held low sends unframed all ones on the line.
// - Alarm pin high again resumes normal transmit data.
// - Control register alarm bit also forces all ones, pin aside.
// - Lost CRC-4 sync on terminal side sends every E-bit as zero.
// - Lost CRC-4 sync on network side sends every E-bit as one.
// - With CRC-4 sync, E-bits report received block errors.
// - Thirty interrupt sources, each with its own mask bit.
// - After reset only the eight alarm-class interrupts are unmasked.
// - Reset sets the suspend bit so the request output stays idle.
// - Request output is driven only while the suspend bit is zero.
// - Reading the vector clears it and the earlier latched records.
// - Writing zero to a counter byte clears it; the low byte keeps a same-cycle violation.
// - A zero control word disables timeslot substitution.
// - Programmable offset shifts backplane output bits from frame pulse.
// - Line code defaults to HDB3 on bipolar NRZ after reset.
// - Remote loopback sends received data out without retiming.
// - Normal mode places receive data relative to received alignment.
// - Normal mode replaces channel zero, and 16 if enabled, on transmit.
// - Pass-through ignores alignment on receive, leaves transmit unaltered.
// - Pass-through keeps line code, interrupts, loops, counter working.
// - Software or hardware reset clears CRC-modify, mode, framing-select.
// - Pass-through is 0,1,1; normal framing is 0,0,0.
// - Transparent mode corrects CRC bit for altered data link bit.
module efc_framer_ctrl
    import efc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic txAlarmForceN,
    input wire logic backplaneClock2m,
    input wire logic framePulseInN,
    input wire logic serialInStream,
    input wire logic rxLineData,
    input wire logic crc4SyncLost,
    input wire logic crcBlockError,
    input wire logic lineCodeViolation,
    input wire logic [29:0] irqEvent,
    output logic txLineData,
    output logic serialOutStream,
    output logic interruptRequestN,
    output logic [1:0] lineCodeSelect
);

    efc_state_type cur_reg;
    efc_state_type cur_next;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        efc_state_type n;
        efc_mode_type modeSel;
        logic clkRise;
        logic clkFall;
        logic aisOn;
        logic eBit;
        logic txBit;
        logic [7:0] writeIdx;
        logic [7:0] readIdx;
        logic [2:0] bitInSlot;
        logic [6:0] fasNext;
        logic [29:0] events;
        logic [7:0] rdValue;
        logic vioOverflow;
        logic [7:0] lastSrc;
        n = cur_reg;
        modeSel = EFC_OTHER;
        clkRise = 1'b0;
        clkFall = 1'b0;
        aisOn = 1'b0;
        eBit = 1'b0;
        txBit = 1'b0;
        writeIdx = 8'h00;
        readIdx = 8'h00;
        bitInSlot = 3'h0;
        fasNext = 7'h00;
        events = 30'h00000000;
        rdValue = 8'h00;
        vioOverflow = 1'b0;
        lastSrc = 8'h00;

        // ****************************************
        // Pin synchronisers
        // ****************************************
        n.alarmSync = {cur_reg.alarmSync[1:0], txAlarmForceN};
        n.clkSync = {cur_reg.clkSync[1:0], backplaneClock2m};
        n.pulseSync = {cur_reg.pulseSync[1:0], framePulseInN};
        n.dinSync = {cur_reg.dinSync[1:0], serialInStream};
        n.rxSync = {cur_reg.rxSync[1:0], rxLineData};
        if (cur_reg.alarmSync[1] == cur_reg.alarmSync[2]) begin
            n.alarmPin = cur_reg.alarmSync[2];
        end
        if (cur_reg.clkSync[1] == cur_reg.clkSync[2]) begin
            n.clkLevel = cur_reg.clkSync[2];
        end
        if (cur_reg.pulseSync[1] == cur_reg.pulseSync[2]) begin
            n.pulseLevel = cur_reg.pulseSync[2];
        end
        if (cur_reg.dinSync[1] == cur_reg.dinSync[2]) begin
            n.dinLevel = cur_reg.dinSync[2];
        end
        if (cur_reg.rxSync[1] == cur_reg.rxSync[2]) begin
            n.rxLevel = cur_reg.rxSync[2];
        end
        clkRise = n.clkLevel & ~cur_reg.clkLevel;
        clkFall = ~n.clkLevel & cur_reg.clkLevel;

        // ****************************************
        // Mode decode
        // ****************************************
        case ({cur_reg.ctrl[`EFC_CTRL_CRC_MODIFY_ENABLE], cur_reg.ctrl[`EFC_CTRL_MODE],
               cur_reg.ctrl[`EFC_CTRL_ALIGN]})
            3'b000: modeSel = EFC_NORMAL;
            3'b110: modeSel = EFC_TRANSPARENT;
            3'b011: modeSel = EFC_PASS;
            default: modeSel = EFC_OTHER;
        endcase

        // ****************************************
        // Transmit path
        // ****************************************
        aisOn = ~cur_reg.alarmPin | cur_reg.ctrl[`EFC_CTRL_ALARM];
        if (crc4SyncLost) begin
            eBit = ~cur_reg.ctrl[`EFC_CTRL_SIDE];
        end else begin
            eBit = ~cur_reg.crcErrSeen;
        end
        bitInSlot = cur_reg.bitCnt[2:0];
        txBit = cur_reg.dinBit;
        if (crcBlockError) begin
            n.crcErrSeen = 1'b1;
        end
        case (modeSel)
            EFC_NORMAL: begin
                if (cur_reg.bitCnt[7:3] == 5'h00) begin
                    if (!cur_reg.frameOdd) begin
                        txBit = (bitInSlot == 3'h0) ? 1'b1 : 1'(`EFC_FAS_WORD >> (3'h7 - bitInSlot));
                    end else begin
                        case (bitInSlot)
                            3'h0: txBit = eBit;
                            3'h1: txBit = 1'b1;
                            3'h2: txBit = 1'b0;
                            3'h3: txBit = cur_reg.dlBit;
                            default: txBit = 1'b1;
                        endcase
                    end
                end else if (cur_reg.ctrl[`EFC_CTRL_TS16] &&
                             cur_reg.ts16Val != 8'h00 &&
                             cur_reg.bitCnt[7:3] == 5'(`EFC_TS16_FIRST >> 3)) begin
                    txBit = cur_reg.ts16Val[3'h7 - bitInSlot];
                end
            end
            EFC_TRANSPARENT: begin
                if (cur_reg.bitCnt == 8'h03 && cur_reg.frameOdd) begin
                    txBit = cur_reg.dlBit;
                end else if (cur_reg.bitCnt == 8'h00 && !cur_reg.frameOdd) begin
                    txBit = cur_reg.dinBit ^ cur_reg.crcFix;
                end
            end
            default: txBit = cur_reg.dinBit;
        endcase
        if (clkRise) begin
            if (modeSel == EFC_NORMAL && cur_reg.frameOdd && cur_reg.bitCnt == 8'h00) begin
                n.crcErrSeen = crcBlockError;
            end
            if (modeSel == EFC_TRANSPARENT) begin
                if (cur_reg.bitCnt == 8'h03 && cur_reg.frameOdd &&
                    cur_reg.dinBit != cur_reg.dlBit) begin
                    n.crcFix = ~cur_reg.crcFix;
                end else if (cur_reg.bitCnt == 8'h00 && !cur_reg.frameOdd) begin
                    n.crcFix = 1'b0;
                end
            end
            if (!cur_reg.ctrl[`EFC_CTRL_LOOP]) begin
                n.txLine = aisOn ? 1'b1 : txBit;
            end
            readIdx = 8'(cur_reg.bitCnt + cur_reg.offset);
            n.serialOut = cur_reg.frameBuf[readIdx];
            n.bitCnt = 8'(cur_reg.bitCnt + 8'h01);
            if (cur_reg.bitCnt == 8'hff) begin
                n.frameOdd = ~cur_reg.frameOdd;
            end
        end
        if (cur_reg.ctrl[`EFC_CTRL_LOOP]) begin
            n.txLine = aisOn ? 1'b1 : cur_reg.rxLevel;
        end

        // ****************************************
        // Receive path and frame pulse
        // ****************************************
        if (clkFall) begin
            n.dinBit = cur_reg.dinLevel;
            if (!cur_reg.pulseLevel) begin
                n.bitCnt = 8'h00;
            end
            writeIdx = (modeSel == EFC_PASS) ? cur_reg.bitCnt : cur_reg.rxPos;
            n.frameBuf[writeIdx] = cur_reg.rxLevel;
            n.rxHist = {cur_reg.rxHist[5:0], cur_reg.rxLevel};
            fasNext = {cur_reg.rxHist[5:0], cur_reg.rxLevel};
            if (modeSel != EFC_PASS && fasNext == `EFC_FAS_WORD) begin
                n.rxPos = `EFC_AFTER_FAS;
            end else begin
                n.rxPos = 8'(cur_reg.rxPos + 8'h01);
            end
        end

        // ****************************************
        // Violation counter
        // ****************************************
        if (lineCodeViolation) begin
            n.vioCnt = 16'(cur_reg.vioCnt + 16'h0001);
            vioOverflow = (cur_reg.vioCnt == 16'hffff);
        end

        // ****************************************
        // Register reads
        // ****************************************
        if (regAddr == `EFC_ADDR_CTRL) begin
            rdValue = cur_reg.ctrl;
        end else if (regAddr == `EFC_ADDR_LINE) begin
            rdValue = {6'h00, cur_reg.lineCode};
        end else if (regAddr == `EFC_ADDR_OFFSET) begin
            rdValue = cur_reg.offset;
        end else if (regAddr == `EFC_ADDR_TS16) begin
            rdValue = cur_reg.ts16Val;
        end else if (regAddr == `EFC_ADDR_MASK0) begin
            rdValue = cur_reg.mask[7:0];
        end else if (regAddr == `EFC_ADDR_MASK1) begin
            rdValue = cur_reg.mask[15:8];
        end else if (regAddr == `EFC_ADDR_MASK2) begin
            rdValue = cur_reg.mask[23:16];
        end else if (regAddr == `EFC_ADDR_MASK3) begin
            rdValue = {2'h0, cur_reg.mask[29:24]};
        end else if (regAddr == `EFC_ADDR_PEND0) begin
            rdValue = cur_reg.pend[7:0];
        end else if (regAddr == `EFC_ADDR_PEND1) begin
            rdValue = cur_reg.pend[15:8];
        end else if (regAddr == `EFC_ADDR_PEND2) begin
            rdValue = cur_reg.pend[23:16];
        end else if (regAddr == `EFC_ADDR_PEND3) begin
            rdValue = {2'h0, cur_reg.pend[29:24]};
        end else if (regAddr == `EFC_ADDR_STATUS) begin
            rdValue = {3'h0, modeSel == EFC_PASS, crc4SyncLost, aisOn,
                       cur_reg.crcErrSeen, ~cur_reg.irqN};
        end else if (regAddr == `EFC_ADDR_VECTOR) begin
            rdValue = cur_reg.vector;
        end else if (regAddr == `EFC_ADDR_DLINK) begin
            rdValue = {7'h00, cur_reg.dlBit};
        end else if (regAddr == `EFC_ADDR_VIO_HI) begin
            rdValue = cur_reg.vioCnt[15:8];
        end else if (regAddr == `EFC_ADDR_VIO_LO) begin
            rdValue = cur_reg.vioCnt[7:0];
        end
        n.rdData = regRd ? rdValue : 8'h00;
        if (regRd && regAddr == `EFC_ADDR_VECTOR) begin
            n.vector = 8'h00;
            n.pend = 30'h00000000;
        end

        // ****************************************
        // Register writes
        // ****************************************
        if (regWr) begin
            if (regAddr == `EFC_ADDR_CTRL) begin
                n.ctrl = regWrData;
            end else if (regAddr == `EFC_ADDR_LINE) begin
                n.lineCode = regWrData[1:0];
                if (regWrData[`EFC_LINE_SWRST]) begin
                    n.ctrl[`EFC_CTRL_CRC_MODIFY_ENABLE] = 1'b0;
                    n.ctrl[`EFC_CTRL_MODE] = 1'b0;
                    n.ctrl[`EFC_CTRL_ALIGN] = 1'b0;
                end
            end else if (regAddr == `EFC_ADDR_OFFSET) begin
                n.offset = regWrData;
            end else if (regAddr == `EFC_ADDR_TS16) begin
                n.ts16Val = regWrData;
            end else if (regAddr == `EFC_ADDR_MASK0) begin
                n.mask[7:0] = regWrData;
            end else if (regAddr == `EFC_ADDR_MASK1) begin
                n.mask[15:8] = regWrData;
            end else if (regAddr == `EFC_ADDR_MASK2) begin
                n.mask[23:16] = regWrData;
            end else if (regAddr == `EFC_ADDR_MASK3) begin
                n.mask[29:24] = regWrData[5:0];
            end else if (regAddr == `EFC_ADDR_DLINK) begin
                n.dlBit = regWrData[0];
            end else if (regAddr == `EFC_ADDR_VIO_HI) begin
                if (regWrData == 8'h00) begin
                    n.vioCnt[15:8] = 8'h00;
                end
            end else if (regAddr == `EFC_ADDR_VIO_LO) begin
                if (regWrData == 8'h00) begin
                    n.vioCnt[7:0] = {7'h00, lineCodeViolation};
                end
            end
        end

        // ****************************************
        // Interrupt capture, set wins over clear
        // ****************************************
        events = irqEvent;
        events[`EFC_IRQ_VIO_OVF] = irqEvent[`EFC_IRQ_VIO_OVF] | vioOverflow;
        for (int i = 0; i < `EFC_IRQ_COUNT; i++) begin
            if (events[i]) begin
                n.pend[i] = 1'b1;
                if (cur_reg.mask[i]) begin
                    lastSrc = 8'(i + 1);
                end
            end
        end
        if (lastSrc != 8'h00) begin
            n.vector = lastSrc;
        end
        n.irqN = ~(~n.ctrl[`EFC_CTRL_SUSPEND] & |(n.pend & n.mask));

        // ****************************************
        // Reset values
        // ****************************************
        if (sys_rst) begin
            n = '0;
            n.pulseSync = 3'h7;
            n.pulseLevel = 1'b1;
            n.ctrl = `EFC_CTRL_RESET;
            n.lineCode = `EFC_LINE_CODE_RESET;
            n.mask = `EFC_MASK_RESET;
            n.irqN = 1'b1;
            n.txLine = 1'b1;
        end
        cur_next = n;
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk) begin
        cur_reg <= cur_next;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign regRdData = cur_reg.rdData;
    assign txLineData = cur_reg.txLine;
    assign serialOutStream = cur_reg.serialOut;
    assign interruptRequestN = cur_reg.irqN;
    assign lineCodeSelect = cur_reg.lineCode;

endmodule : efc_framer_ctrl

//--- sim/efc_framer_ctrl_asserts.sv
module efc_framer_ctrl_asserts (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    input wire logic txAlarmForceN,
    input wire logic rxLineData,
    input wire logic lineCodeViolation,
    input wire logic [29:0] irqEvent,
    input wire logic txLineData,
    input wire logic interruptRequestN,
    input wire logic [1:0] lineCodeSelect
);
    // ****************************************
    // Control register shadow and alarm duration counters
    // ****************************************
    typedef struct packed {
        logic [7:0] ctrl;
        logic [4:0] pinLow;
        logic [4:0] bitOn;
    } efc_chk_state_type;
    efc_chk_state_type chkReg;
    efc_chk_state_type chkNext;
    logic loopOk;
    always_comb begin
        chkNext = chkReg;
        if (regWr && regAddr == 8'h00) begin
            chkNext.ctrl = regWrData;
        end else if (regWr && regAddr == 8'h01 && regWrData[7]) begin
            chkNext.ctrl = chkReg.ctrl & 8'h1f;
        end
        chkNext.pinLow = txAlarmForceN ? 5'h00 : chkReg.pinLow + 5'(chkReg.pinLow != 5'h1f);
        chkNext.bitOn = chkReg.ctrl[0] ? chkReg.bitOn + 5'(chkReg.bitOn != 5'h1f) : 5'h00;
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chkReg <= {8'h04, 10'h000};
        end else begin
            chkReg <= chkNext;
        end
    end
    assign loopOk = chkReg.ctrl[3] && !chkReg.ctrl[0] && txAlarmForceN;
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence rdCtrl;
        regRd && regAddr == 8'h00;
    endsequence
    sequence quietVec;
        regRd && regAddr == 8'h12 && irqEvent == 30'h0 && !lineCodeViolation;
    endsequence
    sequence rdVec;
        regRd && regAddr == 8'h12;
    endsequence
    sequence clrLow;
        regWr && regAddr == 8'h1d && regWrData == 8'h00 && !lineCodeViolation;
    endsequence
    sequence rdLow;
        regRd && regAddr == 8'h1d;
    endsequence
    a_alarm_pin_ones: assert property (chkReg.pinLow > 5'h13 |-> txLineData)
        else $error("Line not all ones under alarm pin");
    a_alarm_reg_ones: assert property (chkReg.bitOn > 5'h13 |-> txLineData)
        else $error("Line not all ones under alarm bit");
    a_suspend_holds: assert property (chkReg.ctrl[2] && $past(chkReg.ctrl[2])
        |-> interruptRequestN) else $error("Request active while suspended");
    a_ctrl_readback: assert property (rdCtrl |=> regRdData == $past(chkReg.ctrl))
        else $error("Control readback wrong");
    a_code_reset: assert property ($fell(sys_rst) |-> lineCodeSelect == 2'h0)
        else $error("Line code not default after reset");
    a_code_write: assert property (regWr && regAddr == 8'h01 |=>
        {6'h00, lineCodeSelect} == ($past(regWrData) & 8'h03)) else $error("Line code wrong");
    a_vector_clear: assert property (quietVec ##1 rdVec |=> regRdData == 8'h00)
        else $error("Vector not cleared by read");
    a_vio_clear: assert property (clrLow ##1 rdLow |=> regRdData == 8'h00)
        else $error("Counter byte not cleared");
    a_loop_follows: assert property ((loopOk && $stable(rxLineData)) [*8]
        |-> txLineData == rxLineData) else $error("Loopback data wrong");
endmodule : efc_framer_ctrl_asserts

bind efc_framer_ctrl efc_framer_ctrl_asserts u_chk (.clk(clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .txAlarmForceN(txAlarmForceN), .rxLineData(rxLineData),
    .lineCodeViolation(lineCodeViolation), .irqEvent(irqEvent), .txLineData(txLineData),
    .interruptRequestN(interruptRequestN), .lineCodeSelect(lineCodeSelect));

//--- sim/efc_bp_model.sv
module efc_bp_model (
    output logic bpClk,
    output logic fpN,
    output logic sDat
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // Free running backplane clock, frame pulse
    // ****************************************
    logic [7:0] cnt;
    initial begin
        bpClk = 1'b0;
        fpN = 1'b1;
        sDat = 1'b0;
        cnt = 8'h00;
        forever begin
            #62.5 bpClk = ~bpClk;
            if (bpClk) begin
                cnt = cnt + 8'h01;
                fpN = (cnt != 8'h00);
            end
        end
    end
endmodule : efc_bp_model

//--- sim/efc_framer_ctrl_tb.sv
module efc_framer_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, sys_rst, regWr, regRd, txAlarmForceN, bpClk, fpN, sDat, rxLineData;
    logic crc4SyncLost, crcBlockError, lineCodeViolation, txLineData, interruptRequestN;
    logic serialOutStream;
    logic [7:0] regAddr, regWrData, regRdData, d;
    logic [29:0] irqEvent;
    logic [1:0] lineCodeSelect;
    logic [519:0] cap;
    logic [23:0] rows [8];
    int bad_count, n_checks, cycles;
    efc_bp_model bp (.bpClk(bpClk), .fpN(fpN), .sDat(sDat));
    efc_framer_ctrl dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .txAlarmForceN(txAlarmForceN), .backplaneClock2m(bpClk), .framePulseInN(fpN),
        .serialInStream(sDat), .rxLineData(rxLineData), .crc4SyncLost(crc4SyncLost),
        .crcBlockError(crcBlockError), .lineCodeViolation(lineCodeViolation),
        .irqEvent(irqEvent), .txLineData(txLineData), .serialOutStream(serialOutStream),
        .interruptRequestN(interruptRequestN), .lineCodeSelect(lineCodeSelect));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt
    task automatic regWrite(input logic [7:0] a, input logic [7:0] v);
        regAddr <= a;
        regWrData <= v;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask : regWrite
    task automatic regRead(input logic [7:0] a, output logic [7:0] v);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 v = regRdData;
    endtask : regRead
    task automatic pulseEv(input int b);
        irqEvent <= 30'h1 << b;
        @(posedge clk);
        irqEvent <= 30'h0;
        wt(4);
    endtask : pulseEv
    task automatic capBits(input int n);
        cap = '0;
        repeat (n) begin
            @(negedge bpClk);
            cap = {cap[518:0], txLineData};
        end
        wt(1);
    endtask : capBits
    task automatic frameCheck(input logic expE);
        int f;
        int t;
        capBits(520);
        f = -1;
        for (int i = 0; i < 512; i++) if (f < 0 && cap[519 - i -: 8] === 8'h9b) f = i;
        check("fas found", {7'h0, f >= 0}, 8'h01);
        if (f >= 0) begin
            t = (f < 256) ? f + 256 : f - 256;
            check("odd word", {4'h0, cap[519 - t -: 4]}, {4'h0, expE, 3'b101});
            t = (f < 384) ? f + 128 : f - 128;
            check("ts16 byte", cap[519 - t -: 8], 8'ha5);
        end
    endtask : frameCheck
    // ****************************************
    // Clock, timeout, sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 50000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        {sys_rst, txAlarmForceN, crc4SyncLost} = 3'b101;
        {regWr, regRd, rxLineData, crcBlockError, lineCodeViolation} = 5'h0;
        {regAddr, regWrData, irqEvent} = '0;
        rows = '{24'h020505, 24'h03a5a5, 24'h053c3c, 24'h07ff3f, 24'h140101, 24'h08ff00,
            24'h12ff00, 24'h205500};
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        wt(1);
        regRead(8'h00, d);
        check("ctrl reset", d, 8'h04);
        regRead(8'h04, d);
        check("mask0 reset", d, 8'hff);
        for (int i = 5; i < 8; i++) begin
            regRead(8'(i), d);
            check("mask reset", d, 8'h00);
        end
        check("code reset", {6'h0, lineCodeSelect}, 8'h00);
        capBits(300);
        check("ais pin", {7'h0, &cap[299:0]}, 8'h01);
        for (int i = 0; i < 8; i++) begin
            regWrite(rows[i][23:16], rows[i][15:8]);
            regRead(rows[i][23:16], d);
            check($sformatf("row %0d", i), d, rows[i][7:0]);
        end
        pulseEv(3);
        check("irq suspended", {7'h0, interruptRequestN}, 8'h01);
        regRead(8'h12, d);
        check("vector", d, 8'h04);
        regWrite(8'h00, 8'h00);
        pulseEv(9);
        check("irq masked", {7'h0, interruptRequestN}, 8'h01);
        pulseEv(4);
        check("irq active", {7'h0, interruptRequestN}, 8'h00);
        regRead(8'h12, d);
        check("vector", d, 8'h05);
        regRead(8'h12, d);
        check("vector clear", d, 8'h00);
        wt(3);
        check("irq idle", {7'h0, interruptRequestN}, 8'h01);
        repeat (3) begin
            lineCodeViolation <= 1'b1;
            wt(1);
            lineCodeViolation <= 1'b0;
            wt(1);
        end
        regRead(8'h1d, d);
        check("vio low", d, 8'h03);
        regWrite(8'h1d, 8'h00);
        regRead(8'h1d, d);
        check("vio low clr", d, 8'h00);
        regWrite(8'h1c, 8'h00);
        regRead(8'h1c, d);
        check("vio high clr", d, 8'h00);
        txAlarmForceN <= 1'b1;
        regWrite(8'h00, 8'h16);
        frameCheck(1'b0);
        regWrite(8'h00, 8'h14);
        frameCheck(1'b1);
        crc4SyncLost <= 1'b0;
        regWrite(8'h00, 8'h16);
        frameCheck(1'b1);
        regWrite(8'h00, 8'h05);
        capBits(64);
        check("ais reg", {7'h0, &cap[63:0]}, 8'h01);
        regWrite(8'h00, 8'h0c);
        rxLineData <= 1'b1;
        wt(10);
        check("loop one", {7'h0, txLineData}, 8'h01);
        rxLineData <= 1'b0;
        wt(10);
        check("loop zero", {7'h0, txLineData}, 8'h00);
        regWrite(8'h00, 8'hc4);
        rxLineData <= 1'b1;
        regWrite(8'h01, 8'h03);
        check("code pass", {6'h0, lineCodeSelect}, 8'h03);
        capBits(520);
        check("pass data", {7'h0, cap === 520'h0}, 8'h01);
        check("pass rx", {7'h0, serialOutStream}, 8'h01);
        regWrite(8'h01, 8'h83);
        regRead(8'h00, d);
        check("soft reset", d, 8'h04);
        regWrite(8'h00, 8'he4);
        sys_rst <= 1'b1;
        wt(3);
        sys_rst <= 1'b0;
        wt(1);
        regRead(8'h00, d);
        check("hard reset", d, 8'h04);
        check("code again", {6'h0, lineCodeSelect}, 8'h00);
        give_verdict();
    end
endmodule : efc_framer_ctrl_tb
